/* File: sdff_pkg.sv */
// Package for the sector data field framer: byte values, field lengths, CRC constants.
// Assumes a byte-wide write/read channel clocked at the byte rate.
package sdff_pkg;
	localparam logic [7:0] SDFF_SYNC_BYTE = 8'ha1;
	localparam logic [7:0] SDFF_ADDR_MARK = 8'hf8;
	localparam logic [7:0] SDFF_GAP_BYTE = 8'h00;
	localparam int SDFF_DATA_LEN = 512;
	localparam int SDFF_CRC_LEN = 2;
	localparam int SDFF_TURNOFF_LEN = 3;
	localparam int SDFF_VFO_LOCK_LEN = 13;
	localparam int SDFF_IRG_LEN = 15;
	localparam logic [15:0] SDFF_CRC_POLY = 16'h1021;
	localparam logic [15:0] SDFF_CRC_PRESET = 16'hffff;
	localparam int SDFF_CLOCK_HZ = 20000000;
	typedef enum logic [2:0] {
		SDFF_IDLE, SDFF_SYNC, SDFF_MARK, SDFF_DATA, SDFF_CRC, SDFF_TOFF, SDFF_IRG
	} sdff_state_t;
	// One byte step of the CRC, MSB first
	function automatic logic [15:0] sdff_crc_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ b[i]) ? ((c << 1) ^ SDFF_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
endpackage

/* File: sdff_skid.sv */
// Two-entry buffer between host byte source and framer.
// Assumes both sides on the same clock; ready/valid handshakes.
`timescale 1ns/1ps
module sdff_skid import sdff_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end
	logic [WIDTH-1:0] mem_q [2];
	logic [WIDTH-1:0] mem_d [2];
	logic [1:0] cnt_q, cnt_d;
	logic rd_q, rd_d, wr_q, wr_d;
	logic push, pop;
	// Occupancy and pointers
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		cnt_d = cnt_q + 2'(push) - 2'(pop);
		wr_d = push ? ~wr_q : wr_q;
		rd_d = pop ? ~rd_q : rd_q;
		mem_d = mem_q;
		if (push) begin
			mem_d[wr_q] = in_data;
		end
	end
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cnt_q <= 2'h0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			mem_q <= '{default: '0};
		end else begin
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			mem_q <= mem_d;
		end
	end
	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
	a_skid_no_overflow: assert property (@(posedge clock) disable iff (!rstn)
		cnt_q <= 2'h2) else $error("buffer count above two");
endmodule

/* File: sdff_framer.sv */
// Sector data field framer: writes sync, mark, 512 data, CRC, turn-off and IRG; checks sync, mark, data and CRC on read.
// Assumes byte-rate clock, host byte stream with valid/ready, and a byte-aligned read channel.
//
// Functional notes
// RQ1: A single F8 address mark byte is sent before the data, and on read it marks the start of data.
// RQ2: Exactly 512 user bytes follow the mark, taken from or given to the host in order.
// RQ3: Two CRC bytes follow the data, and on read a mismatch flags the field invalid.
// RQ4: Three zero bytes follow the CRC on every data field update to isolate the write splice.
// RQ5: The trailing zero gap leaves room for the 13 zero bytes used for VFO lock of the next ID field.
// RQ6: An inter-record gap of 15 zero bytes follows each sector's data field.
// RQ7: One A1 sync byte with a missing clock bit precedes the mark, and on read it gives byte alignment.
// RQ8: The CRC uses x^16+x^12+x^5+1, preset to ones, over sync, mark and data, high byte first.
`timescale 1ns/1ps
module sdff_framer import sdff_pkg::*; #(
	parameter int DATA_LEN = SDFF_DATA_LEN
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic wr_start,
	input wire logic [7:0] host_data,
	input wire logic host_valid,
	output logic host_ready,
	output logic [7:0] wr_byte,
	output logic wr_byte_valid,
	output logic wr_missing_clock,
	output logic wr_busy,
	input wire logic rd_enable,
	input wire logic [7:0] rd_byte,
	input wire logic rd_byte_valid,
	input wire logic rd_sync_found,
	output logic [7:0] rd_data,
	output logic rd_data_valid,
	output logic rd_done,
	output logic rd_crc_error
);
	// Turn-off zeros, then the inter-record gap; together they form one zero run
	localparam int TAIL_LEN = SDFF_TURNOFF_LEN;
	localparam int GAP_LEN = SDFF_IRG_LEN;
	localparam int ZERO_RUN = TAIL_LEN + GAP_LEN;
	// The zero run must also hold the next ID field's VFO lock span, so no extra bytes are sent
	initial begin
		if (DATA_LEN < 1 || DATA_LEN > 65535) $error("DATA_LEN out of range");
		if (ZERO_RUN < SDFF_VFO_LOCK_LEN) $error("zero run shorter than lock span"); // see RQ5
	end

	// ----------------------------------------
	// Host buffer
	// ----------------------------------------
	logic [7:0] buf_data;
	logic buf_valid, buf_ready;
	sdff_skid #(.WIDTH(8)) u_skid (
		.clock(clock),
		.rstn(rstn),
		.in_data(host_data),
		.in_valid(host_valid),
		.in_ready(host_ready),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready)
	);

	// ----------------------------------------
	// Write sequencer
	// ----------------------------------------
	sdff_state_t st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] crc_q, crc_d;
	logic [7:0] wb_q, wb_d;
	logic wv_q, wv_d, mc_q, mc_d;
	// One byte per clock; the data phase stalls when the host buffer runs dry
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		crc_d = crc_q;
		wb_d = SDFF_GAP_BYTE;
		wv_d = 1'b0;
		mc_d = 1'b0;
		buf_ready = 1'b0;
		case (st_q)
			SDFF_IDLE: begin
				if (wr_start) begin
					st_d = SDFF_SYNC;
				end
			end
			SDFF_SYNC: begin
				wb_d = SDFF_SYNC_BYTE; // see RQ7
				wv_d = 1'b1;
				mc_d = 1'b1; // see RQ7
				crc_d = sdff_crc_byte(SDFF_CRC_PRESET, SDFF_SYNC_BYTE); // see RQ8
				st_d = SDFF_MARK;
			end
			SDFF_MARK: begin
				wb_d = SDFF_ADDR_MARK; // see RQ1
				wv_d = 1'b1;
				crc_d = sdff_crc_byte(crc_q, SDFF_ADDR_MARK); // see RQ8
				cnt_d = 16'h0;
				st_d = SDFF_DATA;
			end
			SDFF_DATA: begin
				buf_ready = 1'b1;
				if (buf_valid) begin
					wb_d = buf_data; // see RQ2
					wv_d = 1'b1;
					crc_d = sdff_crc_byte(crc_q, buf_data); // see RQ8
					cnt_d = cnt_q + 16'h1;
					if (cnt_q == 16'(DATA_LEN - 1)) begin
						cnt_d = 16'h0;
						st_d = SDFF_CRC;
					end
				end
			end
			SDFF_CRC: begin
				wb_d = (cnt_q == 16'h0) ? crc_q[15:8] : crc_q[7:0]; // see RQ3, RQ8
				wv_d = 1'b1;
				cnt_d = cnt_q + 16'h1;
				if (cnt_q == 16'(SDFF_CRC_LEN - 1)) begin
					cnt_d = 16'h0;
					st_d = SDFF_TOFF;
				end
			end
			SDFF_TOFF: begin
				wv_d = 1'b1; // see RQ4
				cnt_d = cnt_q + 16'h1;
				if (cnt_q == 16'(TAIL_LEN - 1)) begin
					cnt_d = 16'h0;
					st_d = SDFF_IRG;
				end
			end
			SDFF_IRG: begin
				// Zeros here also serve the next ID field's VFO lock span
				wv_d = 1'b1; // see RQ5, RQ6
				cnt_d = cnt_q + 16'h1;
				if (cnt_q == 16'(GAP_LEN - 1)) begin
					cnt_d = 16'h0;
					st_d = SDFF_IDLE;
				end
			end
			default: st_d = SDFF_IDLE;
		endcase
	end
	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_q <= SDFF_IDLE;
			cnt_q <= 16'h0;
			crc_q <= SDFF_CRC_PRESET;
			wb_q <= 8'h00;
			wv_q <= 1'b0;
			mc_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			crc_q <= crc_d;
			wb_q <= wb_d;
			wv_q <= wv_d;
			mc_q <= mc_d;
		end
	end
	assign wr_byte = wb_q;
	assign wr_byte_valid = wv_q;
	assign wr_missing_clock = mc_q;
	assign wr_busy = (st_q != SDFF_IDLE);

	// ----------------------------------------
	// Read checker
	// ----------------------------------------
	typedef enum logic [2:0] {SDFF_R_HUNT, SDFF_R_MARK, SDFF_R_DATA, SDFF_R_CRC} sdff_rstate_t;
	sdff_rstate_t rs_q, rs_d;
	logic [15:0] rcnt_q, rcnt_d, rcrc_q, rcrc_d;
	logic [7:0] rd_q, rd_d;
	logic rv_q, rv_d, rdone_q, rdone_d, rerr_q, rerr_d;
	// Sync realigns, mark opens data, residue of zero after CRC means good
	always_comb begin
		rs_d = rs_q;
		rcnt_d = rcnt_q;
		rcrc_d = rcrc_q;
		rd_d = rd_q;
		rv_d = 1'b0;
		rdone_d = 1'b0;
		rerr_d = rerr_q;
		if (!rd_enable) begin
			rs_d = SDFF_R_HUNT;
		end else if (rd_byte_valid) begin
			case (rs_q)
				SDFF_R_HUNT: begin
					if (rd_sync_found && rd_byte == SDFF_SYNC_BYTE) begin // see RQ7
						rcrc_d = sdff_crc_byte(SDFF_CRC_PRESET, rd_byte); // see RQ8
						rs_d = SDFF_R_MARK;
					end
				end
				SDFF_R_MARK: begin
					if (rd_byte == SDFF_ADDR_MARK) begin // see RQ1
						rcrc_d = sdff_crc_byte(rcrc_q, rd_byte);
						rcnt_d = 16'h0;
						rerr_d = 1'b0;
						rs_d = SDFF_R_DATA;
					end else begin
						rs_d = SDFF_R_HUNT;
					end
				end
				SDFF_R_DATA: begin
					rd_d = rd_byte; // see RQ2
					rv_d = 1'b1;
					rcrc_d = sdff_crc_byte(rcrc_q, rd_byte);
					rcnt_d = rcnt_q + 16'h1;
					if (rcnt_q == 16'(DATA_LEN - 1)) begin
						rcnt_d = 16'h0;
						rs_d = SDFF_R_CRC;
					end
				end
				SDFF_R_CRC: begin
					rcrc_d = sdff_crc_byte(rcrc_q, rd_byte);
					rcnt_d = rcnt_q + 16'h1;
					if (rcnt_q == 16'(SDFF_CRC_LEN - 1)) begin
						rdone_d = 1'b1;
						rerr_d = (rcrc_d != 16'h0000); // see RQ3
						rs_d = SDFF_R_HUNT;
					end
				end
				default: rs_d = SDFF_R_HUNT;
			endcase
		end
	end
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rs_q <= SDFF_R_HUNT;
			rcnt_q <= 16'h0;
			rcrc_q <= SDFF_CRC_PRESET;
			rd_q <= 8'h00;
			rv_q <= 1'b0;
			rdone_q <= 1'b0;
			rerr_q <= 1'b0;
		end else begin
			rs_q <= rs_d;
			rcnt_q <= rcnt_d;
			rcrc_q <= rcrc_d;
			rd_q <= rd_d;
			rv_q <= rv_d;
			rdone_q <= rdone_d;
			rerr_q <= rerr_d;
		end
	end
	assign rd_data = rd_q;
	assign rd_data_valid = rv_q;
	assign rd_done = rdone_q;
	assign rd_crc_error = rerr_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_sync_sent;
		wr_byte_valid && wr_byte == SDFF_SYNC_BYTE && wr_missing_clock;
	endsequence
	sequence s_mark_sent;
		wr_byte_valid && wr_byte == SDFF_ADDR_MARK && !wr_missing_clock;
	endsequence
	a_mark_after_sync: assert property (@(posedge clock) disable iff (!rstn) // see RQ1
		s_sync_sent |=> s_mark_sent) else $error("mark did not follow sync");
	a_sync_after_start: assert property (@(posedge clock) disable iff (!rstn) // see RQ7
		(st_q == SDFF_IDLE && wr_start) |=> ##1 s_sync_sent) else $error("sync not sent after start");
	a_data_count: assert property (@(posedge clock) disable iff (!rstn) // see RQ2
		(st_q == SDFF_DATA && cnt_q == 16'(DATA_LEN - 1) && buf_valid) |=> st_q == SDFF_CRC)
		else $error("data count wrong");
	a_crc_high_first: assert property (@(posedge clock) disable iff (!rstn) // see RQ8
		(st_q == SDFF_CRC && cnt_q == 16'h0) |=> wr_byte == $past(crc_q[15:8])) else $error("crc high byte wrong");
	a_crc_two_bytes: assert property (@(posedge clock) disable iff (!rstn) // see RQ3
		$rose(st_q == SDFF_CRC) |-> (st_q == SDFF_CRC) [*2] ##1 st_q == SDFF_TOFF) else $error("crc length wrong");
	a_toff_zeros: assert property (@(posedge clock) disable iff (!rstn) // see RQ4
		$rose(st_q == SDFF_TOFF) |=> (wr_byte == 8'h00 && wr_byte_valid) [*3]) else $error("turn-off not zero");
	a_irg_length: assert property (@(posedge clock) disable iff (!rstn) // see RQ6
		$rose(st_q == SDFF_IRG) |-> ##15 st_q == SDFF_IDLE) else $error("gap length wrong");
	a_gap_covers_vfo: assert property (@(posedge clock) disable iff (!rstn) // see RQ5
		$rose(st_q == SDFF_TOFF) |-> ##ZERO_RUN st_q == SDFF_IDLE)
		else $error("gap shorter than lock span");
	a_read_flag_done: assert property (@(posedge clock) disable iff (!rstn) // see RQ3
		rd_done |-> rd_crc_error == (rcrc_q != 16'h0000)) else $error("crc flag mismatch");
endmodule

/* File: sdff_chan_model.sv */
// Drive read/write channel model: records the written track and replays it as read-back.
// Assumes a byte-aligned channel on the framer's byte clock.
`timescale 1ns/1ps
module sdff_chan_model (
	input wire logic clock,
	input wire logic [7:0] wr_byte,
	input wire logic wr_byte_valid,
	input wire logic wr_missing_clock,
	output logic [7:0] rd_byte,
	output logic rd_byte_valid,
	output logic rd_sync_found
);
	logic [8:0] rec[$];
	// Idle channel at time zero
	initial begin
		rd_byte = 8'h00;
		rd_byte_valid = 1'b0;
		rd_sync_found = 1'b0;
	end
	// Record each written byte together with its missing-clock mark
	always @(posedge clock) begin
		if (wr_byte_valid === 1'b1) begin
			rec.push_back({wr_missing_clock, wr_byte});
		end
	end
	// Replay the track; flip corrupts one byte, gap slows the channel
	task automatic replay(input int flip, input int gap);
		for (int i = 0; i < rec.size(); i++) begin
			@(posedge clock);
			rd_byte <= rec[i][7:0] ^ ((i == flip) ? 8'h01 : 8'h00);
			rd_byte_valid <= 1'b1;
			rd_sync_found <= rec[i][8];
			for (int g = 0; g < gap; g++) begin
				@(posedge clock);
				rd_byte <= ~rec[i][7:0]; // Stale value never looks valid
				rd_byte_valid <= 1'b0;
				rd_sync_found <= 1'b0;
			end
		end
		@(posedge clock);
		rd_byte_valid <= 1'b0;
		rd_sync_found <= 1'b0;
		rd_byte <= ~rd_byte;
		rec.delete();
	endtask
endmodule

/* File: test_sector_data_field_framer.sv */
// Testbench for the sector data field framer: writes sectors, replays them through the channel model.
// Assumes the framer with a shortened data length and the channel model in sdff_chan_model.sv.
`timescale 1ns/1ps
module test_sector_data_field_framer import sdff_pkg::*;;
	localparam int DLEN = 4; // Short field keeps the run brief
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic wr_start = 1'b0;
	logic [7:0] host_data = 8'h00;
	logic host_valid = 1'b0;
	logic rd_enable = 1'b0;
	logic host_ready, wr_byte_valid, wr_missing_clock, wr_busy;
	logic rd_byte_valid, rd_sync_found, rd_data_valid, rd_done, rd_crc_error;
	logic [7:0] wr_byte, rd_byte, rd_data;
	logic [31:0] seed = 32'h00000058;
	logic [8:0] exp_wr[$];
	logic [7:0] exp_rd[$];
	logic exp_err[$];
	int failures = 0;
	int samples_checked = 0;

	sdff_framer #(.DATA_LEN(DLEN)) sdff_framer_i (.clock(clock), .rstn(rstn), .wr_start(wr_start),
		.host_data(host_data), .host_valid(host_valid), .host_ready(host_ready), .wr_byte(wr_byte),
		.wr_byte_valid(wr_byte_valid), .wr_missing_clock(wr_missing_clock), .wr_busy(wr_busy),
		.rd_enable(rd_enable), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
		.rd_sync_found(rd_sync_found), .rd_data(rd_data), .rd_data_valid(rd_data_valid),
		.rd_done(rd_done), .rd_crc_error(rd_crc_error));
	sdff_chan_model sdff_chan_model_i (.clock(clock), .wr_byte(wr_byte), .wr_byte_valid(wr_byte_valid),
		.wr_missing_clock(wr_missing_clock), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
		.rd_sync_found(rd_sync_found));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	always #25 clock = ~clock;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Own bitwise CRC, MSB first, so expectations do not share the design's code
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
		end
		return c;
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Watcher: oldest note against each result
	// ----------------------------------------
	always @(posedge clock) begin
		if (wr_byte_valid === 1'b1) begin
			if (exp_wr.size() == 0) check("extra write byte", 16'h0001, 16'h0000);
			else check("write byte", {7'h00, wr_missing_clock, wr_byte}, {7'h00, exp_wr.pop_front()});
		end
		if (rd_data_valid === 1'b1) begin
			if (exp_rd.size() == 0) check("extra read byte", 16'h0001, 16'h0000);
			else check("read byte", {8'h00, rd_data}, {8'h00, exp_rd.pop_front()});
		end
		if (rd_done === 1'b1) begin
			if (exp_err.size() == 0) check("extra done", 16'h0001, 16'h0000);
			else check("crc flag", {15'h0000, rd_crc_error}, {15'h0000, exp_err.pop_front()});
		end
	end

	// ----------------------------------------
	// Write one sector, noting the whole expected track first
	// ----------------------------------------
	task automatic write_sector();
		logic [7:0] d[DLEN];
		logic [15:0] crc;
		crc = crc_step(crc_step(16'hffff, 8'ha1), 8'hf8);
		exp_wr.push_back({1'b1, 8'ha1});
		exp_wr.push_back({1'b0, 8'hf8});
		for (int i = 0; i < DLEN; i++) begin
			d[i] = 8'(rnd());
			crc = crc_step(crc, d[i]);
			exp_wr.push_back({1'b0, d[i]});
			exp_rd.push_back(d[i]);
		end
		exp_wr.push_back({1'b0, crc[15:8]});
		exp_wr.push_back({1'b0, crc[7:0]});
		for (int i = 0; i < 18; i++) exp_wr.push_back(9'h000);
		@(posedge clock);
		wr_start <= 1'b1;
		@(posedge clock);
		wr_start <= 1'b0;
		// Host feeds bytes with random stalls
		for (int i = 0; i < DLEN; i++) begin
			host_data <= d[i];
			host_valid <= 1'b1;
			@(negedge clock);
			while (host_ready !== 1'b1) @(negedge clock);
			@(posedge clock);
			if (rnd() % 2) begin
				host_valid <= 1'b0;
				@(posedge clock);
			end
		end
		host_valid <= 1'b0;
		wr_start <= 1'b1; // Start while busy must be ignored
		@(posedge clock);
		wr_start <= 1'b0;
		for (int k = 0; k < 200 && wr_busy !== 1'b0; k++) @(negedge clock);
		@(negedge clock); // Last gap byte stands in the cycle busy drops and is noted one edge later
		check("busy after field", {15'h0000, wr_busy}, 16'h0000);
		check("write notes left", 16'(exp_wr.size()), 16'h0000);
	endtask

	// ----------------------------------------
	// Main sequence: good pair back to back, bad CRC, bad mark
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		rd_enable <= 1'b1;
		check("ready after reset", {15'h0000, host_ready}, 16'h0001);
		for (int c = 0; c < 3; c++) begin
			write_sector();
			if (c == 0) write_sector();
			if (c == 0) exp_err.push_back(1'b0);
			if (c == 2) exp_rd.delete(); // Wrong mark: no data at all
			else exp_err.push_back(c == 1);
			sdff_chan_model_i.replay((c == 1) ? DLEN + 2 : ((c == 2) ? 1 : -1), c);
			repeat (4) @(posedge clock);
			check("read notes left", 16'(exp_rd.size()), 16'h0000);
			check("done notes left", 16'(exp_err.size()), 16'h0000);
			$display("test %0d done", c);
		end
		wrap_up();
	end
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#(50 * 5000);
		failures++;
		wrap_up();
	end
endmodule
